//--- rs_fec_defines.vh
// Purpose: Constants for the forward error correction mode control block
// Assumes: Word-aligned classic Wishbone register map, 32-bit data
// Notes: Offsets are byte addresses
`ifndef RS_FEC_DEFINES_VH
`define RS_FEC_DEFINES_VH

// Register byte offsets
`define REG_STATUS 4'h0
`define REG_EVENT 4'h4
`define REG_MASK 4'h8
`define REG_ERRCOUNT 4'hc

// Configuration vector bit positions
`define CFG_FEC_EN 0
`define CFG_CORRECT 1
`define CFG_INDICATE 2
`define CFG_IEEE 3
`define CFG_W 4

// Status register bit positions above the configuration bits
`define ST_DEC_BYPASS 4
`define ST_HI_SER 5
`define ST_TX_LOCK 6
`define ST_TX_ALIGN 7

// Event bit positions
`define EV_HI_SER 0
`define EV_UNCORR 1
`define EV_LOCK_LOST 2
`define EV_ALIGN_LOST 3
`define EV_W 4

// Reset values
`define MASK_RESET 4'h0
`define EVENT_RESET 4'h0

// Symbol error rate monitor
`define SER_WINDOW_CW 14'h2000
`define SER_THRESHOLD 16'h01a1
`define SER_CNT_W 16
`define CW_ERR_W 4

// Startup capture point: start counter value; modes load on the next edge, the third after reset release
`define CAPTURE_AT 2'h2

`endif

//--- rs_fec_mode_control.v
// Purpose: Mode selection and status for an optional Reed-Solomon correction stage
// Assumes: One clock, config pins static around reset, decoder strobes synchronous
// Notes: Wishbone classic slave, one wait state; single level interrupt
//
// Function
// - Function enable 1 inserts the stage; 0 bypasses it straight to transceiver.
// - All configuration inputs captured once after reset; later changes are ignored.
// - Correction enable 0 means detect only; 1 also corrects correctable codewords.
// - Indication enable 1 flags uncorrectable codewords to PCS; 0 bypasses flagging.
// - Correct without indication: data corrected, no error marks, lower latency.
// - Conformance mode 1 is standard; 0 with both enables 0 bypasses decoder.
// - No-indication setting counts symbol errors per codeword block, drives high rate flag.
// - High rate flag only in no-indication setting; errors above 417 per 8192 codewords.
// - Correction and indication enables mirror management bits 1.200.0 and 1.200.1.
// - Transmit PCS block lock reported on an output, 1 locked.
// - Transmit PCS frame alignment reported on an output, 1 aligned.
`timescale 1ns/10ps
`include "rs_fec_defines.vh"

module rs_fec_mode_control (
    input wire clk,
    input wire rst_n,
    // Static configuration pins
    input wire fec_enable_pin,
    input wire correction_enable_pin,
    input wire indication_enable_pin,
    input wire ieee_mode_pin,
    // Decoder per-codeword report
    input wire cw_done,
    input wire [3:0] cw_symbol_errors,
    input wire cw_uncorrectable,
    // Transmit PCS state
    input wire tx_block_lock_in,
    input wire tx_lane_aligned_in,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Datapath steering, status and interrupt
    output reg fec_inserted,
    output reg decoder_correct,
    output reg decoder_indicate,
    output reg decoder_bypass,
    output reg error_mark,
    output reg high_symbol_error_rate,
    output reg high_symbol_error_rate_status,
    output reg tx_block_lock,
    output reg tx_lane_aligned,
    output reg irq
);

    function [3:0] reg_sel;
        input [3:0] adr;
        begin
            reg_sel = 4'h0;
            case (adr)
                `REG_STATUS: reg_sel = 4'h1;
                `REG_EVENT: reg_sel = 4'h2;
                `REG_MASK: reg_sel = 4'h4;
                `REG_ERRCOUNT: reg_sel = 4'h8;
                default: reg_sel = 4'h0;
            endcase
        end
    endfunction

    reg [`CFG_W-1:0] cfg_meta;
    reg [`CFG_W-1:0] cfg_sync;
    reg [`CFG_W-1:0] cfg;
    reg [1:0] start_cnt;
    reg boot_state;
    reg next_boot_state;
    reg [13:0] win_cnt;
    reg [`SER_CNT_W-1:0] err_cnt;
    reg ser_hit;
    reg [`EV_W-1:0] events;
    reg [`EV_W-1:0] mask;
    reg [`EV_W-1:0] ev_in;
    reg lock_q;
    reg align_q;
    reg [`SER_CNT_W-1:0] err_add;
    reg err_sat;
    reg [`SER_CNT_W-1:0] err_next;
    reg err_over;
    reg win_end;
    reg next_hi;

    // Startup states: wait for the synchroniser, then freeze the modes
    localparam ST_WAIT = 1'b0;
    localparam ST_RUN = 1'b1;

    wire fec_on = cfg[`CFG_FEC_EN];
    wire dec_byp = fec_on & ~cfg[`CFG_IEEE] & ~cfg[`CFG_CORRECT] & ~cfg[`CFG_INDICATE];
    wire ser_mode = fec_on & ~dec_byp & ~cfg[`CFG_INDICATE];

    function over_threshold;
        input [`SER_CNT_W-1:0] sum;
        begin
            over_threshold = (sum > `SER_THRESHOLD);
        end
    endfunction

    // Window sum saturates rather than wrapping back under the threshold
    always @* begin
        err_add = err_cnt + {{(`SER_CNT_W-`CW_ERR_W){1'b0}}, cw_symbol_errors};
        err_sat = (err_add < err_cnt);
        if (err_sat) begin
            err_next = {`SER_CNT_W{1'b1}};
        end else begin
            err_next = err_add;
        end
        err_over = over_threshold(err_next);
        win_end = cw_done & (win_cnt == `SER_WINDOW_CW - 14'h1);
        next_hi = ser_mode & (ser_hit | (cw_done & err_over));
    end

    wire bus_req = wb_cyc_i & wb_stb_i;
    wire bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire [3:0] hit = reg_sel(wb_adr_i);
    wire [`EV_W-1:0] w1c = (bus_wr & hit[1]) ? wb_dat_i[`EV_W-1:0] : {`EV_W{1'b0}};

    // Two-flop synchroniser on the configuration pins
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_meta <= {`CFG_W{1'b0}};
            cfg_sync <= {`CFG_W{1'b0}};
        end else begin
            cfg_meta <= {ieee_mode_pin, indication_enable_pin, correction_enable_pin, fec_enable_pin};
            cfg_sync <= cfg_meta;
        end
    end

    // Capture once, as soon as synchronised values are valid
    always @* begin
        next_boot_state = boot_state;
        case (boot_state)
            ST_WAIT: begin
                if (start_cnt == `CAPTURE_AT) begin
                    next_boot_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_boot_state = ST_RUN;
            end
            default: begin
                next_boot_state = ST_WAIT;
            end
        endcase
    end

    // Later pin moves are ignored until the next reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_state <= ST_WAIT;
            start_cnt <= 2'h0;
            cfg <= {`CFG_W{1'b0}};
        end else begin
            boot_state <= next_boot_state;
            if (boot_state == ST_WAIT) begin
                start_cnt <= start_cnt + 2'h1;
            end
            if ((boot_state == ST_WAIT) && (next_boot_state == ST_RUN)) begin
                cfg <= cfg_sync;
            end
        end
    end

    // Steering outputs; bypassed stage lets the PCS see the transceiver directly
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fec_inserted <= 1'b0;
            decoder_correct <= 1'b0;
            decoder_indicate <= 1'b0;
            decoder_bypass <= 1'b0;
            error_mark <= 1'b0;
        end else begin
            fec_inserted <= fec_on;
            decoder_correct <= fec_on & ~dec_byp & cfg[`CFG_CORRECT];
            decoder_indicate <= fec_on & ~dec_byp & cfg[`CFG_INDICATE];
            decoder_bypass <= dec_byp;
            // No marks when indication is off, even while correcting
            error_mark <= fec_on & cfg[`CFG_INDICATE] & cw_done & cw_uncorrectable;
        end
    end

    // Symbol error rate monitor over non-overlapping windows
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt <= 14'h0;
            err_cnt <= {`SER_CNT_W{1'b0}};
            ser_hit <= 1'b0;
            high_symbol_error_rate <= 1'b0;
            high_symbol_error_rate_status <= 1'b0;
        end else begin
            if (!ser_mode) begin
                win_cnt <= 14'h0;
                err_cnt <= {`SER_CNT_W{1'b0}};
                ser_hit <= 1'b0;
            end else if (cw_done) begin
                if (win_end) begin
                    // Flag holds through the next window; it then reflects that window
                    win_cnt <= 14'h0;
                    err_cnt <= {`SER_CNT_W{1'b0}};
                    ser_hit <= 1'b0;
                end else begin
                    win_cnt <= win_cnt + 14'h1;
                    err_cnt <= err_next;
                    ser_hit <= ser_hit | err_over;
                end
            end
            if (!ser_mode) begin
                high_symbol_error_rate <= 1'b0;
            end else if (win_end) begin
                high_symbol_error_rate <= ser_hit | err_over;
            end else if (next_hi) begin
                high_symbol_error_rate <= 1'b1;
            end
            high_symbol_error_rate_status <= ser_mode & (win_end ?
                (ser_hit | err_over) : (high_symbol_error_rate | next_hi));
        end
    end

    // Transmit side status, forced inactive while the stage is out
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_block_lock <= 1'b0;
            tx_lane_aligned <= 1'b0;
            lock_q <= 1'b0;
            align_q <= 1'b0;
        end else begin
            tx_block_lock <= fec_on & tx_block_lock_in;
            tx_lane_aligned <= fec_on & tx_lane_aligned_in;
            lock_q <= tx_block_lock;
            align_q <= tx_lane_aligned;
        end
    end

    always @* begin
        ev_in = {`EV_W{1'b0}};
        ev_in[`EV_HI_SER] = ser_mode & next_hi & ~high_symbol_error_rate;
        ev_in[`EV_UNCORR] = fec_on & cw_done & cw_uncorrectable;
        ev_in[`EV_LOCK_LOST] = lock_q & ~tx_block_lock;
        ev_in[`EV_ALIGN_LOST] = align_q & ~tx_lane_aligned;
    end

    // Sticky events; a new event beats a same-cycle clear
    genvar g;
    generate
        for (g = 0; g < `EV_W; g = g + 1) begin : ev_bit
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    events[g] <= 1'b0;
                end else if (ev_in[g]) begin
                    events[g] <= 1'b1;
                end else if (w1c[g]) begin
                    events[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Bus slave: ack one cycle after request, writes land on the ack edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            // Read data is latched with the ack and held until the next read
            if (bus_req & ~wb_ack_o & ~wb_we_i) begin
                case (1'b1)
                    hit[0]: wb_dat_o <= {24'h0, align_q, lock_q, high_symbol_error_rate,
                        dec_byp, cfg};
                    hit[1]: wb_dat_o <= {28'h0, events};
                    hit[2]: wb_dat_o <= {28'h0, mask};
                    hit[3]: wb_dat_o <= {16'h0, err_cnt};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // Mask and interrupt; irq lags the event bits by one edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= `MASK_RESET;
            irq <= 1'b0;
        end else begin
            if (bus_wr & hit[2]) begin
                mask <= wb_dat_i[`EV_W-1:0];
            end
            irq <= |(events & mask);
        end
    end

endmodule

//--- rs_fec_mode_control_monitor.sv
// Purpose: Assertions on the correction mode control ports
// Assumes: One clock, rst_n active low
// Notes: Bound into every instance of the block
`timescale 1ns/10ps
module rs_fec_mode_control_monitor (
    input wire clk,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire cw_done,
    input wire cw_uncorrectable,
    input wire tx_block_lock_in,
    input wire tx_lane_aligned_in,
    input wire fec_inserted,
    input wire decoder_correct,
    input wire decoder_indicate,
    input wire decoder_bypass,
    input wire error_mark,
    input wire high_symbol_error_rate,
    input wire high_symbol_error_rate_status,
    input wire tx_block_lock,
    input wire tx_lane_aligned
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
    property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack one cycle after request");
    property p_mark; decoder_indicate && cw_done && cw_uncorrectable |=> error_mark; endproperty
    a_mark: assert property (p_mark) else $error("uncorrectable codeword not marked");
    property p_no_mark; fec_inserted && !decoder_indicate && cw_done |=> !error_mark; endproperty
    a_no_mark: assert property (p_no_mark) else $error("mark while indication off");
    property p_off; !fec_inserted |-> !high_symbol_error_rate && !tx_block_lock && !tx_lane_aligned; endproperty
    a_off: assert property (p_off) else $error("status active with stage skipped");
    property p_copy; high_symbol_error_rate_status == high_symbol_error_rate; endproperty
    a_copy: assert property (p_copy) else $error("rate flag copies differ");
    property p_lock; fec_inserted |=> tx_block_lock == $past(tx_block_lock_in)
        && tx_lane_aligned == $past(tx_lane_aligned_in); endproperty
    a_lock: assert property (p_lock) else $error("transmit status not tracking");
    property p_bypass; decoder_bypass |-> fec_inserted && !decoder_correct && !decoder_indicate; endproperty
    a_bypass: assert property (p_bypass) else $error("bypass with decoder active");
    property p_hiser; $rose(high_symbol_error_rate) |-> fec_inserted && !decoder_indicate && !decoder_bypass;
    endproperty
    a_hiser: assert property (p_hiser) else $error("rate flag outside no-indication");
endmodule
bind rs_fec_mode_control rs_fec_mode_control_monitor i_mon (.*);

//--- rs_fec_mode_control_tb_top.sv
// Purpose: Self-checking bench for the correction mode control block
// Assumes: Stand-in drives decoder reports
// Notes: Lock inputs high except in the lock scenario
`timescale 1ns/10ps
`include "rs_fec_defines.vh"
module rs_fec_mode_control_tb_top;
    reg clk = 1'b0, rst_n = 1'b0, send = 1'b0, bad = 1'b0, cyc = 1'b0, we = 1'b0, mark_seen = 1'b0;
    reg [3:0] cfg = 4'h0, errs = 4'h0, adr = 4'h0;
    reg lk_in = 1'b1, al_in = 1'b1;
    reg [31:0] wdat = 32'h0, rd;
    wire [31:0] dat_o;
    wire [3:0] se;
    wire ack, done, unc, ins, cor, ind, byp, mark, hs, hss, lk, al, irq;
    integer err_total = 0, num_checks = 0;
    rs_fec_mode_control i_dut (.clk(clk), .rst_n(rst_n), .fec_enable_pin(cfg[0]), .correction_enable_pin(cfg[1]),
        .indication_enable_pin(cfg[2]), .ieee_mode_pin(cfg[3]), .cw_done(done), .cw_symbol_errors(se),
        .cw_uncorrectable(unc), .tx_block_lock_in(lk_in), .tx_lane_aligned_in(al_in), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .fec_inserted(ins), .decoder_correct(cor), .decoder_indicate(ind), .decoder_bypass(byp), .error_mark(mark),
        .high_symbol_error_rate(hs), .high_symbol_error_rate_status(hss), .tx_block_lock(lk), .tx_lane_aligned(al),
        .irq(irq));
    rs_fec_pcs_model i_pcs (.clk(clk), .rst_n(rst_n), .send(send), .errs(errs), .bad(bad), .cw_done(done),
        .cw_symbol_errors(se), .cw_uncorrectable(unc));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (mark) mark_seen <= 1'b1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
    endtask
    task automatic boot(input logic [3:0] c);
        rst_n <= 1'b0;
        cfg <= c;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        cfg <= ~c; // Late pin changes must not reach the modes
        repeat (4) @(posedge clk);
        mark_seen <= 1'b0;
    endtask
    task automatic cw(input int n, input logic [3:0] e, input logic b);
        errs <= e;
        bad <= b;
        send <= 1'b1;
        repeat (n) @(posedge clk);
        send <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_modes;
        logic [3:0] tab [5] = '{4'hf, 4'hb, 4'hd, 4'h1, 4'h0};
        logic b;
        foreach (tab[i]) begin
            boot(tab[i]);
            b = tab[i][0] & ~tab[i][3] & ~tab[i][1] & ~tab[i][2];
            chk(ins, tab[i][0]);
            chk(cor, tab[i][0] & ~b & tab[i][1]);
            chk(ind, tab[i][0] & ~b & tab[i][2]);
            chk(byp, b);
            chk({lk, al}, {2{tab[i][0]}});
            wb(1'b0, `REG_STATUS, 32'h0);
            chk(rd[4:0], {b, tab[i]});
        end
    endtask
    task automatic t_mark;
        boot(4'hf);
        wb(1'b1, `REG_MASK, 32'h2);
        cw(1, 4'h3, 1'b1);
        chk({mark_seen, irq}, 2'h3);
        wb(1'b1, `REG_EVENT, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        cw(30, 4'hf, 1'b0);
        chk(hs, 1'b0);
        boot(4'hb);
        cw(1, 4'h3, 1'b1);
        chk({mark_seen, irq}, 2'h0);
    endtask
    task automatic t_hiser;
        cw(26, 4'hf, 1'b0);
        cw(2, 4'hc, 1'b0);
        chk(hs, 1'b0);
        wb(1'b0, `REG_ERRCOUNT, 32'h0);
        chk(rd, 32'h1a1);
        cw(1, 4'h1, 1'b0);
        chk({hs, hss}, 2'h3);
        cw(8163, 4'h0, 1'b0);
        chk(hs, 1'b1);
        cw(8192, 4'h0, 1'b0);
        chk(hs, 1'b0);
    endtask
    task automatic t_lock;
        boot(4'h1);
        wb(1'b1, `REG_MASK, 32'hc);
        lk_in <= 1'b0;
        repeat (4) @(posedge clk);
        chk({lk, al, irq}, 3'h3);
        al_in <= 1'b0;
        repeat (4) @(posedge clk);
        chk(al, 1'b0);
        wb(1'b0, `REG_EVENT, 32'h0);
        chk(rd, 32'hc);
        wb(1'b0, `REG_STATUS, 32'h0);
        chk(rd[7:6], 2'h0);
        lk_in <= 1'b1;
        al_in <= 1'b1;
        repeat (4) @(posedge clk);
        chk({lk, al}, 2'h3);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        t_modes;
        t_mark;
        t_hiser;
        t_lock;
        end_sim;
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        end_sim;
    end
endmodule

//--- rs_fec_pcs_model.sv
// Purpose: Decoder report stand-in for the mode control block
// Assumes: Requests come from the bench
// Notes: Fields scrambled outside a report, never left at old values
`timescale 1ns/10ps
module rs_fec_pcs_model #(parameter MARKER_GAP = 20480) (
    input wire clk,
    input wire rst_n,
    input wire send,
    input wire [3:0] errs,
    input wire bad,
    output reg cw_done,
    output reg [3:0] cw_symbol_errors,
    output reg cw_uncorrectable
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {cw_done, cw_symbol_errors, cw_uncorrectable} <= 6'h00;
        end else begin
            cw_done <= send;
            cw_symbol_errors <= send ? errs : ~cw_symbol_errors;
            cw_uncorrectable <= send ? bad : ~cw_uncorrectable;
        end
    end
endmodule
